// [hw/mad_motion_detect.sv]
// What this block does
// (R1) Activity compares axis magnitude with threshold
// (R2) Activity threshold: low byte, three high bits
// (R3) Thresholds compared in raw codes, unscaled
// (R4) Activity after count of consecutive over-samples
// (R5) Activity count zero acts as one
// (R6) Wake-up mode: single sample declares activity
// (R7) Inactivity compares axis magnitude with threshold
// (R8) Inactivity threshold: low byte, three high bits
// (R9) Inactivity after count of all-under samples
// (R10) Inactivity count: low byte, then high byte
// (R11) Inactivity counter spans full sixteen bits
// (R12) Inactivity count zero acts as one
// (R13) Default mode: independent, flags held until read
// (R14) Linked: one armed, host reads to acknowledge
// (R15) Loop: alternate, events acknowledged internally
// (R16) Linked or loop needs both enables set
// (R17) Control bit 3 selects referenced inactivity
// (R18) Control bit 2 enables inactivity detector
// (R19) Control bit 1 selects referenced activity
// (R20) Control bit 0 enables activity detector
// (R21) Activity event sets activity status flag
// (R22) Inactivity event sets inactivity status flag
// (R23) Awake reads one outside linked or loop
// (R24) Activity arms inactivity; inactivity arms activity
// (R25) Referenced mode compares against armed-time sample
// (R26) Counters step per sample, restart on failure
//
// Purpose: activity and inactivity detection behind the byte register port
// Assumes: register port and samples come from logic on clk_i
// Notes: read data appears one cycle after the read strobe
`timescale 1ns/1ps
module mad_motion_detect
   import mad_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_i,
   input wire mad_reg_req_t reg_req_i,
   output logic [7:0] reg_rdata_o,
   input wire logic sample_valid_i,
   input wire mad_sample_t sample_i,
   input wire logic wakeup_mode_i,
   output logic activity_flag_o,
   output logic inactivity_flag_o,
   output logic awake_o
);

   // Register storage
   logic [7:0] act_thr_lo_q;
   logic [THR_HI_W-1:0] act_thr_hi_q;
   logic [7:0] act_count_q;
   logic [7:0] inactivity_flag_thr_lo_q;
   logic [THR_HI_W-1:0] inactivity_flag_thr_hi_q;
   logic [7:0] inactivity_flag_cnt_lo_q;
   logic [7:0] inactivity_flag_cnt_hi_q;
   logic [7:0] ctl_q;
   logic soft_q;
   logic clr;

   // Detector state
   logic act_flag_q;
   logic inactivity_flag_flag_q;
   logic awake_q;
   mad_phase_t phase_q;
   mad_sample_t last_q;
   mad_sample_t activity_referenced_select_q;
   mad_sample_t inactivity_referenced_select_q;
   logic act_armed_q;
   logic inactivity_flag_armed_q;

   // Derived control
   logic activity_enable;
   logic inactivity_enable;
   logic link_on;
   logic loop_on;
   logic act_armed;
   logic inactivity_flag_armed;
   logic act_evt;
   logic inactivity_flag_evt;
   logic status_rd;
   logic [10:0] act_thr;
   logic [10:0] inactivity_flag_thr;
   logic [15:0] act_need;
   logic [15:0] inactivity_flag_need;
   mad_sample_t activity_referenced_select;
   mad_sample_t inactivity_referenced_select;
   mad_sample_t zero_sample;
   logic [7:0] rdata;

   // Soft reset clears everything like the pin reset
   assign clr = reset_i || soft_q;

   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         soft_q <= 1'b0;
      end
      else
      begin
         soft_q <= reg_req_i.wr && reg_req_i.addr == ADDR_SOFT_RESET && reg_req_i.wdata == SOFT_RESET_CODE;
      end
   end

   // Register writes; bits above the threshold field are not kept
   always_ff @(posedge clk_i)
   begin
      if (clr)
      begin
         act_thr_lo_q <= RESET_BYTE;
         act_thr_hi_q <= RESET_THR_HI;
         act_count_q <= RESET_BYTE;
         inactivity_flag_thr_lo_q <= RESET_BYTE;
         inactivity_flag_thr_hi_q <= RESET_THR_HI;
         inactivity_flag_cnt_lo_q <= RESET_BYTE;
         inactivity_flag_cnt_hi_q <= RESET_BYTE;
         ctl_q <= RESET_BYTE;
      end
      else if (reg_req_i.wr)
      begin
         unique case (reg_req_i.addr)
            ADDR_ACT_THR_LO: act_thr_lo_q <= reg_req_i.wdata; // see R2
            ADDR_ACT_THR_HI: act_thr_hi_q <= reg_req_i.wdata[THR_HI_W-1:0]; // see R2
            ADDR_ACT_COUNT: act_count_q <= reg_req_i.wdata;
            ADDR_INACTIVITY_FLAG_THR_LO: inactivity_flag_thr_lo_q <= reg_req_i.wdata; // see R8
            ADDR_INACTIVITY_FLAG_THR_HI: inactivity_flag_thr_hi_q <= reg_req_i.wdata[THR_HI_W-1:0]; // see R8
            ADDR_INACTIVITY_FLAG_CNT_LO: inactivity_flag_cnt_lo_q <= reg_req_i.wdata; // see R10
            ADDR_INACTIVITY_FLAG_CNT_HI: inactivity_flag_cnt_hi_q <= reg_req_i.wdata; // see R10
            ADDR_CONTROL: ctl_q <= reg_req_i.wdata;
            default: ;
         endcase
      end
   end

   // Assembled fields
   assign act_thr = {act_thr_hi_q, act_thr_lo_q}; // see R2
   assign inactivity_flag_thr = {inactivity_flag_thr_hi_q, inactivity_flag_thr_lo_q}; // see R8
   assign inactivity_flag_need = {inactivity_flag_cnt_hi_q, inactivity_flag_cnt_lo_q}; // see R10 see R11
   // Wake-up mode forces a single-sample decision
   assign act_need = wakeup_mode_i ? 16'h0001 : {8'h00, act_count_q}; // see R6

   // Mode decode; linked or loop only with both enables
   assign activity_enable = ctl_q[CTL_ACTIVITY_ENABLE]; // see R20
   assign inactivity_enable = ctl_q[CTL_INACTIVITY_ENABLE]; // see R18
   assign link_on = ctl_q[CTL_LINK] && activity_enable && inactivity_enable; // see R16
   assign loop_on = link_on && ctl_q[CTL_LOOP]; // see R15

   // Only one detector armed when linked
   assign act_armed = activity_enable && (!link_on || phase_q == PH_WAIT_ACT); // see R14 see R20
   assign inactivity_flag_armed = inactivity_enable && (!link_on || phase_q == PH_WAIT_INACTIVITY_FLAG); // see R14 see R18

   // Absolute mode compares against zero; first armed cycle uses the capture source
   assign zero_sample = '0;
   assign activity_referenced_select = !ctl_q[CTL_ACTIVITY_REFERENCED_SELECT] ? zero_sample : (act_armed_q ? activity_referenced_select_q : last_q); // see R19 see R25
   assign inactivity_referenced_select = !ctl_q[CTL_INACTIVITY_REFERENCED_SELECT] ? zero_sample : (inactivity_flag_armed_q ? inactivity_referenced_select_q : last_q); // see R17 see R25

   // Latest sample, kept as the reference source
   always_ff @(posedge clk_i)
   begin
      if (clr)
      begin
         last_q <= '0;
      end
      else if (sample_valid_i)
      begin
         last_q <= sample_i;
      end
   end

   // Arming history and reference capture on the arming edge
   always_ff @(posedge clk_i)
   begin
      if (clr)
      begin
         act_armed_q <= 1'b0;
         inactivity_flag_armed_q <= 1'b0;
         activity_referenced_select_q <= '0;
         inactivity_referenced_select_q <= '0;
      end
      else
      begin
         act_armed_q <= act_armed;
         inactivity_flag_armed_q <= inactivity_flag_armed;
         if (act_armed && !act_armed_q)
         begin
            activity_referenced_select_q <= last_q; // see R25
         end
         if (inactivity_flag_armed && !inactivity_flag_armed_q)
         begin
            inactivity_referenced_select_q <= last_q; // see R25
         end
      end
   end

   // Over-threshold detector
   mad_detector u_act (
      .clk_i(clk_i),
      .reset_i(clr),
      .sample_valid_i(sample_valid_i),
      .sample_i(sample_i),
      .ref_i(activity_referenced_select),
      .threshold_i(act_thr),
      .count_i(act_need),
      .over_i(1'b1),
      .armed_i(act_armed),
      .evt_o(act_evt)
   );

   // Under-threshold detector
   mad_detector u_inactivity_flag (
      .clk_i(clk_i),
      .reset_i(clr),
      .sample_valid_i(sample_valid_i),
      .sample_i(sample_i),
      .ref_i(inactivity_referenced_select),
      .threshold_i(inactivity_flag_thr),
      .count_i(inactivity_flag_need),
      .over_i(1'b0),
      .armed_i(inactivity_flag_armed),
      .evt_o(inactivity_flag_evt)
   );

   // Phase and awake state alternate on events when linked
   always_ff @(posedge clk_i)
   begin
      if (clr)
      begin
         phase_q <= PH_WAIT_INACTIVITY_FLAG;
         awake_q <= 1'b1;
      end
      else if (link_on)
      begin
         unique case (phase_q)
            PH_WAIT_ACT:
            begin
               if (act_evt)
               begin
                  phase_q <= PH_WAIT_INACTIVITY_FLAG; // see R24
                  awake_q <= 1'b1; // see R24
               end
            end
            PH_WAIT_INACTIVITY_FLAG:
            begin
               if (inactivity_flag_evt)
               begin
                  phase_q <= PH_WAIT_ACT; // see R24
                  awake_q <= 1'b0; // see R24
               end
            end
            default:
            begin
               phase_q <= PH_WAIT_INACTIVITY_FLAG;
            end
         endcase
      end
   end

   assign status_rd = reg_req_i.rd && reg_req_i.addr == ADDR_STATUS;

   // Sticky flags; a new event wins over the clearing read.
   // Loop mode clears the opposite flag so the host need not service it.
   always_ff @(posedge clk_i)
   begin
      if (clr)
      begin
         act_flag_q <= 1'b0;
         inactivity_flag_flag_q <= 1'b0;
      end
      else
      begin
         if (act_evt)
         begin
            act_flag_q <= 1'b1; // see R21
         end
         else if (status_rd || (loop_on && inactivity_flag_evt))
         begin
            act_flag_q <= 1'b0; // see R13 see R14 see R15
         end
         if (inactivity_flag_evt)
         begin
            inactivity_flag_flag_q <= 1'b1; // see R22
         end
         else if (status_rd || (loop_on && act_evt))
         begin
            inactivity_flag_flag_q <= 1'b0; // see R13 see R14 see R15
         end
      end
   end

   // Read multiplexer; unmapped offsets read zero
   always_comb
   begin
      rdata = 8'h00;
      unique case (reg_req_i.addr)
         ADDR_ACT_THR_LO: rdata = act_thr_lo_q;
         ADDR_ACT_THR_HI: rdata = {5'h00, act_thr_hi_q};
         ADDR_ACT_COUNT: rdata = act_count_q;
         ADDR_INACTIVITY_FLAG_THR_LO: rdata = inactivity_flag_thr_lo_q;
         ADDR_INACTIVITY_FLAG_THR_HI: rdata = {5'h00, inactivity_flag_thr_hi_q};
         ADDR_INACTIVITY_FLAG_CNT_LO: rdata = inactivity_flag_cnt_lo_q;
         ADDR_INACTIVITY_FLAG_CNT_HI: rdata = inactivity_flag_cnt_hi_q;
         ADDR_CONTROL: rdata = ctl_q;
         ADDR_STATUS:
         begin
            rdata[STAT_ACT] = act_flag_q;
            rdata[STAT_INACTIVITY_FLAG] = inactivity_flag_flag_q;
            rdata[STAT_AWAKE] = link_on ? awake_q : 1'b1; // see R23
         end
         default: rdata = 8'h00;
      endcase
   end

   // Registered outputs
   always_ff @(posedge clk_i)
   begin
      if (clr)
      begin
         reg_rdata_o <= 8'h00;
         activity_flag_o <= 1'b0;
         inactivity_flag_o <= 1'b0;
         awake_o <= 1'b1;
      end
      else
      begin
         reg_rdata_o <= reg_req_i.rd ? rdata : 8'h00;
         activity_flag_o <= act_flag_q;
         inactivity_flag_o <= inactivity_flag_flag_q;
         awake_o <= link_on ? awake_q : 1'b1; // see R23
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (clr);

   chk_awake_default: assert property (!link_on |=> awake_o) // see R23
      else $error("awake not one outside linked modes");
   chk_act_flag_set: assert property (act_evt |=> act_flag_q) // see R21
      else $error("activity event did not set flag");
   chk_inactivity_flag_flag_set: assert property (inactivity_flag_evt |=> inactivity_flag_flag_q) // see R22
      else $error("inactivity event did not set flag");
   chk_single_armed: assert property (link_on |-> !(act_armed && inactivity_flag_armed)) // see R14
      else $error("both detectors armed while linked");
   chk_link_fallback: assert property (!(activity_enable && inactivity_enable) |-> !link_on) // see R16
      else $error("linked mode without both enables");
   chk_disabled_quiet: assert property (!activity_enable |-> !act_armed ##1 !act_evt) // see R20
      else $error("activity armed while disabled");
   chk_inactivity_flag_disabled: assert property (!inactivity_enable ##1 !inactivity_enable |-> !inactivity_flag_evt) // see R18
      else $error("inactivity event while disabled");
   chk_loop_autoack: assert property (loop_on && act_evt && !inactivity_flag_evt |=> !inactivity_flag_flag_q) // see R15
      else $error("loop mode left inactivity flag pending");
   chk_status_clear: assert property (status_rd && !act_evt && !link_on |=> !act_flag_q) // see R13
      else $error("status read did not clear activity flag");
   chk_phase_swap: assert property (link_on && phase_q == PH_WAIT_ACT && act_evt |=> phase_q == PH_WAIT_INACTIVITY_FLAG) // see R24
      else $error("activity did not arm inactivity");

   cov_linked_cycle: cover property (link_on && act_evt ##[1:20] inactivity_flag_evt);
   cov_loop_mode: cover property (loop_on && inactivity_flag_evt);
   cov_status_read: cover property (act_flag_q && status_rd);

endmodule : mad_motion_detect

// [hw/mad_pkg.sv]
// Purpose: shared constants and types of the motion activity detector
// Assumes: byte-wide register port, 12-bit signed axis samples
// Notes: register offsets and control field positions live here only
package mad_pkg;

   // Register offsets
   localparam logic [7:0] ADDR_ACT_THR_LO = 8'h20;
   localparam logic [7:0] ADDR_ACT_THR_HI = 8'h21;
   localparam logic [7:0] ADDR_ACT_COUNT = 8'h22;
   localparam logic [7:0] ADDR_INACTIVITY_FLAG_THR_LO = 8'h23;
   localparam logic [7:0] ADDR_INACTIVITY_FLAG_THR_HI = 8'h24;
   localparam logic [7:0] ADDR_INACTIVITY_FLAG_CNT_LO = 8'h25;
   localparam logic [7:0] ADDR_INACTIVITY_FLAG_CNT_HI = 8'h26;
   localparam logic [7:0] ADDR_CONTROL = 8'h27;
   localparam logic [7:0] ADDR_STATUS = 8'h1A;
   localparam logic [7:0] ADDR_SOFT_RESET = 8'h1F;
   localparam logic [7:0] SOFT_RESET_CODE = 8'h52;

   // Reset values
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [2:0] RESET_THR_HI = 3'h0;

   // Control register fields
   localparam int CTL_ACTIVITY_ENABLE = 0;
   localparam int CTL_ACTIVITY_REFERENCED_SELECT = 1;
   localparam int CTL_INACTIVITY_ENABLE = 2;
   localparam int CTL_INACTIVITY_REFERENCED_SELECT = 3;
   localparam int CTL_LINK = 4;
   localparam int CTL_LOOP = 5;

   // Status register fields
   localparam int STAT_ACT = 4;
   localparam int STAT_INACTIVITY_FLAG = 5;
   localparam int STAT_AWAKE = 6;

   // Width of the high threshold field
   localparam int THR_HI_W = 3;

   typedef struct packed {
      logic signed [11:0] x;
      logic signed [11:0] y;
      logic signed [11:0] z;
   } mad_sample_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } mad_reg_req_t;

   // One-hot phase of linked and loop operation
   typedef enum logic [1:0] {
      PH_WAIT_ACT = 2'b01,
      PH_WAIT_INACTIVITY_FLAG = 2'b10
   } mad_phase_t;

   // Magnitude of the difference of two signed samples
   function automatic logic [12:0] mad_abs_diff(input logic signed [11:0] a, input logic signed [11:0] b);
      logic signed [12:0] d;
      d = 13'({a[11], a}) - 13'({b[11], b});
      return d[12] ? 13'(-d) : 13'(d);
   endfunction : mad_abs_diff

endpackage : mad_pkg

// [hw/mad_detector.sv]
// Purpose: one threshold detector with a consecutive-sample counter
// Assumes: sample_valid_i is a one-cycle strobe from the sample path
// Notes: evt_o is a registered pulse one cycle after the deciding sample
`timescale 1ns/1ps
module mad_detector
   import mad_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic sample_valid_i,
   input wire mad_sample_t sample_i,
   input wire mad_sample_t ref_i,
   input wire logic [10:0] threshold_i,
   input wire logic [15:0] count_i,
   input wire logic over_i,
   input wire logic armed_i,
   output logic evt_o
);

   logic [12:0] mag_x;
   logic [12:0] mag_y;
   logic [12:0] mag_z;
   logic [12:0] thr_ext;
   logic qualify;
   logic [15:0] target;
   logic [16:0] cnt_next;
   logic fire;
   logic [15:0] cnt_q;

   // Raw codes are compared; no range scaling here
   assign mag_x = mad_abs_diff(sample_i.x, ref_i.x); // see R1 see R7 see R3
   assign mag_y = mad_abs_diff(sample_i.y, ref_i.y);
   assign mag_z = mad_abs_diff(sample_i.z, ref_i.z);
   assign thr_ext = {2'b00, threshold_i};

   // Any axis over, or every axis under
   assign qualify = over_i ? (mag_x > thr_ext || mag_y > thr_ext || mag_z > thr_ext) // see R4
                           : (mag_x < thr_ext && mag_y < thr_ext && mag_z < thr_ext); // see R9

   // Zero count behaves as one
   assign target = (count_i == 16'h0000) ? 16'h0001 : count_i; // see R5 see R12
   assign cnt_next = {1'b0, cnt_q} + 17'h00001;
   assign fire = sample_valid_i && armed_i && qualify && (cnt_next >= {1'b0, target}); // see R11

   // Counter restarts on a failing sample or when disarmed
   always_ff @(posedge clk_i)
   begin
      if (reset_i || !armed_i)
      begin
         cnt_q <= 16'h0000;
      end
      else if (sample_valid_i)
      begin
         if (!qualify || fire)
         begin
            cnt_q <= 16'h0000; // see R26
         end
         else
         begin
            cnt_q <= cnt_next[15:0]; // see R26
         end
      end
   end

   // Event pulse
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         evt_o <= 1'b0;
      end
      else
      begin
         evt_o <= fire;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   chk_cnt_restart: assert property (sample_valid_i && armed_i && !qualify |=> cnt_q == 16'h0000) // see R26
      else $error("counter did not restart on failing sample");
   chk_event_cause: assert property (evt_o |-> $past(sample_valid_i && armed_i && qualify)) // see R4
      else $error("event without qualifying sample");
   chk_single_sample: assert property (sample_valid_i && armed_i && qualify && count_i <= 16'h0001 |=> evt_o) // see R5
      else $error("single qualifying sample did not fire");
   cov_fire: cover property (sample_valid_i && armed_i && qualify ##1 evt_o);

endmodule : mad_detector

// [test/mad_host_model.sv]
// Purpose: host processor side of the byte register port
// Assumes: requests launched 1 ns after a rising edge of clk_i
// Notes: idle address and data are inverted so stale values never look valid
`timescale 1ns/1ps
module mad_host_model
   import mad_pkg::*;
(
   input wire logic clk_i,
   output mad_reg_req_t reg_req_o,
   input wire logic [7:0] reg_rdata_i
);
   // Quiet port at time zero
   initial reg_req_o = '0;

   // Release: strobes low, qualifiers scrambled
   task automatic idle();
      reg_req_o.wr = 1'b0;
      reg_req_o.rd = 1'b0;
      reg_req_o.addr = ~reg_req_o.addr;
      reg_req_o.wdata = ~reg_req_o.wdata;
   endtask : idle

   // One write, taken at the next edge
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      #1;
      reg_req_o.addr = a;
      reg_req_o.wdata = d;
      reg_req_o.wr = 1'b1;
      @(posedge clk_i);
      #1;
      idle();
   endtask : write_reg

   // One read; a status read is how the host acknowledges events
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i);
      #1;
      reg_req_o.addr = a;
      reg_req_o.rd = 1'b1;
      @(posedge clk_i);
      #1;
      d = reg_rdata_i;
      idle();
   endtask : read_reg
endmodule : mad_host_model

// [test/tb.sv]
// Purpose: self-checking bench of the motion activity detector
// Assumes: inputs change 1 ns after the rising edge, 40 ns clock
// Notes: flags are compared one cycle and 1 ns after their three-cycle latency
`timescale 1ns/1ps
module tb;
   import mad_pkg::*;
   logic clk_i;
   logic reset_i;
   logic sample_valid_i;
   logic wakeup_mode_i;
   logic activity_flag_o;
   logic inactivity_flag_o;
   logic awake_o;
   logic [7:0] reg_rdata_o;
   logic [7:0] rd_v;
   logic [7:0] regs_e [8];
   mad_reg_req_t reg_req_i;
   mad_sample_t sample_i;
   int miscompares;
   int samples_checked;
   int act_n;
   int inactivity_flag_n;
   int act_c;
   int inactivity_flag_c;
   int act_t;
   int inactivity_flag_t;
   logic exp_act;
   logic exp_inactivity_flag;

   // 25 MHz clock
   initial
   begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   mad_motion_detect dut_u (.clk_i(clk_i), .reset_i(reset_i), .reg_req_i(reg_req_i),
      .reg_rdata_o(reg_rdata_o), .sample_valid_i(sample_valid_i), .sample_i(sample_i),
      .wakeup_mode_i(wakeup_mode_i), .activity_flag_o(activity_flag_o),
      .inactivity_flag_o(inactivity_flag_o), .awake_o(awake_o));

   mad_host_model host_u (.clk_i(clk_i), .reg_req_o(reg_req_i), .reg_rdata_i(reg_rdata_o));

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("ERROR %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check

   task automatic conclude();
      $display("compares %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : conclude

   task automatic finished(input string name);
      $display("test %s finished", name);
   endtask : finished

   function automatic int dif(input logic signed [11:0] a, input logic signed [11:0] b);
      int d;
      d = int'(a) - int'(b);
      return (d < 0) ? -d : d;
   endfunction : dif

   // Any axis strictly above, or every axis strictly below
   function automatic logic over(input mad_sample_t s, input mad_sample_t r, input int t);
      return dif(s.x, r.x) > t || dif(s.y, r.y) > t || dif(s.z, r.z) > t;
   endfunction : over

   function automatic logic under(input mad_sample_t s, input mad_sample_t r, input int t);
      return dif(s.x, r.x) < t && dif(s.y, r.y) < t && dif(s.z, r.z) < t;
   endfunction : under

   // Small, or within two codes of a threshold, either sign
   function automatic logic [11:0] rax();
      int m;
      case ($urandom_range(2, 0))
         0: m = int'($urandom_range(20, 0));
         1: m = act_t + int'($urandom_range(4, 0)) - 2;
         default: m = inactivity_flag_t + int'($urandom_range(4, 0)) - 2;
      endcase
      return ($urandom_range(1, 0) != 0) ? 12'(-m) : 12'(m);
   endfunction : rax

   // n back-to-back samples, then wait out the flag latency
   task automatic burst(input mad_sample_t s, input int n);
      @(posedge clk_i);
      #1;
      sample_i = s;
      sample_valid_i = 1'b1;
      repeat (n) @(posedge clk_i);
      #1;
      sample_valid_i = 1'b0;
      sample_i = ~s;
      repeat (3) @(posedge clk_i);
      #1;
   endtask : burst

   task automatic flags(input logic a, input logic i);
      check("activity_flag_o", activity_flag_o, a);
      check("inactivity_flag_o", inactivity_flag_o, i);
   endtask : flags

   task automatic status(input logic aw, input logic i, input logic a);
      host_u.read_reg(ADDR_STATUS, rd_v);
      check("status", rd_v, {1'b0, aw, i, a, 4'h0});
   endtask : status

   // Program all eight registers, control last so counts are in place
   task automatic cfg(input logic [7:0] ctl, input int at, input int an, input int it, input int inn);
      regs_e = '{at[7:0], 8'(at[10:8]), an[7:0], it[7:0], 8'(it[10:8]), inn[7:0], inn[15:8], ctl};
      for (int a = 0; a < 8; a++)
         host_u.write_reg(ADDR_ACT_THR_LO + 8'(a), regs_e[a]);
      act_t = at;
      act_n = an;
      inactivity_flag_t = it;
      inactivity_flag_n = inn;
      act_c = 0;
      inactivity_flag_c = 0;
   endtask : cfg

   // One random sample against the default-mode model
   task automatic rstep();
      mad_sample_t s;
      s = {rax(), rax(), rax()};
      act_c = over(s, '0, act_t) ? act_c + 1 : 0;
      inactivity_flag_c = under(s, '0, inactivity_flag_t) ? inactivity_flag_c + 1 : 0;
      if (act_c >= ((act_n > 1) ? act_n : 1))
      begin
         exp_act = 1'b1;
         act_c = 0;
      end
      if (inactivity_flag_c >= ((inactivity_flag_n > 1) ? inactivity_flag_n : 1))
      begin
         exp_inactivity_flag = 1'b1;
         inactivity_flag_c = 0;
      end
      burst(s, 1);
      flags(exp_act, exp_inactivity_flag);
   endtask : rstep

   // Main sequence
   initial
   begin
      void'($urandom(29));
      reset_i = 1'b1;
      sample_valid_i = 1'b0;
      wakeup_mode_i = 1'b0;
      sample_i = '0;
      miscompares = 0;
      samples_checked = 0;
      exp_act = 1'b0;
      exp_inactivity_flag = 1'b0;
      repeat (20) @(posedge clk_i);
      #1;
      reset_i = 1'b0;
      check("awake_o", awake_o, 1'b1);
      flags(1'b0, 1'b0);
      host_u.write_reg(ADDR_STATUS, 8'hFF);
      host_u.write_reg(8'h30, 8'hFF);
      for (int a = 0; a < 8; a++)
      begin
         host_u.read_reg(ADDR_ACT_THR_LO + 8'(a), rd_v);
         check("reset value", rd_v, 8'h00);
      end
      host_u.read_reg(8'h30, rd_v);
      check("unmapped read", rd_v, 8'h00);
      status(1'b1, 1'b0, 1'b0);
      finished("reset");
      // Random rounds in default mode, absolute thresholds
      for (int r = 0; r < 6; r++)
      begin
         host_u.write_reg(ADDR_CONTROL, 8'h00);
         status(1'b1, exp_inactivity_flag, exp_act);
         exp_act = 1'b0;
         exp_inactivity_flag = 1'b0;
         cfg(8'h05, $urandom_range(2000, 20), $urandom_range(3, 0), $urandom_range(2000, 20), $urandom_range(3, 0));
         for (int a = 0; a < 8; a++)
         begin
            host_u.read_reg(ADDR_ACT_THR_LO + 8'(a), rd_v);
            check("readback", rd_v, regs_e[a]);
         end
         for (int k = 0; k < 30; k++)
         begin
            rstep();
            if (k % 10 == 9)
            begin
               status(1'b1, exp_inactivity_flag, exp_act);
               exp_act = 1'b0;
               exp_inactivity_flag = 1'b0;
            end
         end
      end
      finished("random");
      // Wake-up mode ignores the count; then five consecutive samples needed
      cfg(8'h01, 100, 5, 0, 0);
      wakeup_mode_i = 1'b1;
      burst({12'h065, 24'h000000}, 1);
      flags(1'b1, 1'b0);
      wakeup_mode_i = 1'b0;
      status(1'b1, 1'b0, 1'b1);
      burst({12'h065, 24'h000000}, 4);
      flags(1'b0, 1'b0);
      burst({12'h065, 24'h000000}, 1);
      flags(1'b1, 1'b0);
      cfg(8'h00, 100, 1, 100, 1);
      status(1'b1, 1'b0, 1'b1);
      burst({12'h1F4, 24'h000000}, 1);
      burst('0, 1);
      flags(1'b0, 1'b0);
      finished("wakeup and enables");
      // Long inactivity count 0xFF01, bytes not symmetric
      cfg(8'h04, 0, 0, 100, 32'h0000FF01);
      burst('0, 32'h0000FF00);
      flags(1'b0, 1'b0);
      burst('0, 1);
      flags(1'b0, 1'b1);
      status(1'b1, 1'b1, 1'b0);
      finished("long inactivity");
      // Soft reset clears the registers
      host_u.write_reg(ADDR_SOFT_RESET, SOFT_RESET_CODE);
      repeat (2) @(posedge clk_i);
      host_u.read_reg(ADDR_INACTIVITY_FLAG_CNT_HI, rd_v);
      check("after soft reset", rd_v, 8'h00);
      status(1'b1, 1'b0, 1'b0);
      finished("soft reset");
      // Linked mode: one detector armed, host acknowledges
      cfg(8'h15, 100, 1, 50, 1);
      burst('0, 1);
      flags(1'b0, 1'b1);
      check("awake_o", awake_o, 1'b0);
      host_u.write_reg(ADDR_CONTROL, 8'h14);
      repeat (2) @(posedge clk_i);
      #1;
      check("awake_o", awake_o, 1'b1);
      host_u.write_reg(ADDR_CONTROL, 8'h25);
      repeat (2) @(posedge clk_i);
      #1;
      check("awake_o", awake_o, 1'b1);
      host_u.write_reg(ADDR_CONTROL, 8'h15);
      repeat (2) @(posedge clk_i);
      #1;
      check("awake_o", awake_o, 1'b0);
      status(1'b0, 1'b1, 1'b0);
      burst('0, 1);
      flags(1'b0, 1'b0);
      burst({12'h1F4, 24'h000000}, 1);
      flags(1'b1, 1'b0);
      check("awake_o", awake_o, 1'b1);
      finished("linked");
      // Loop mode: opposite event acknowledges internally
      status(1'b1, 1'b0, 1'b1);
      host_u.write_reg(ADDR_CONTROL, 8'h35);
      burst('0, 1);
      flags(1'b0, 1'b1);
      burst({12'h1F4, 24'h000000}, 1);
      flags(1'b1, 1'b0);
      check("awake_o", awake_o, 1'b1);
      finished("loop");
      // Referenced mode compares against the sample before enabling
      cfg(8'h00, 50, 1, 50, 1);
      status(1'b1, 1'b0, 1'b1);
      burst({12'h3E8, 24'h000000}, 1);
      host_u.write_reg(ADDR_CONTROL, 8'h0F);
      burst({12'h3F2, 24'h000000}, 1);
      flags(1'b0, 1'b1);
      burst({12'h384, 24'h000000}, 1);
      flags(1'b1, 1'b1);
      finished("referenced");
      conclude();
   end

   // Watchdog well past the expected run length
   initial
   begin
      repeat (90000) @(posedge clk_i);
      miscompares++;
      conclude();
   end
endmodule : tb
